/* timer_clock_select_control.sv */
`timescale 1ns/100ps
// Summary of operation
// - Frequency select: 0=32k, 1=4/8M, reset 1
// - External path: off, channel A, channel B
// - External path selected forces crystal off
// - Crystal path: off, path A, path B
// - Crystal powered: external off, path nonzero
// - Kernel clock: PLL, low RC, crystal/external
// - Switch-done flag low during clock change
// - Remap copies update flag to counter bit31
// - Sample clock: divide 1, 2 or 4
// - Divider code 01 halves sample clock
// - Preload off immediate, on buffered reload
// - Edge mode follows direction bit
// - Center 1 flags compares while down
// - Center 2 flags compares while up
// - Center 3 flags compares both ways
// - Direction 0 up, 1 down
// - Direction read-only in center, encoder modes
module timer_clock_select_control
	import timer_clk_ctrl_pkg::*;
#(
	parameter int CNT_W = 16
)
(
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic [7:0]                  adr_i,
	input  wire logic [31:0]                 dat_i,
	input  wire logic [3:0]                  sel_i,
	input  wire logic                        we_i,
	input  wire logic                        cyc_i,
	input  wire logic                        stb_i,
	output logic [31:0]                      dat_o,
	output logic                             ack_o,
	output logic                             err_o,
	output timer_clk_ctrl_pkg::control_t     control_o,
	output timer_clk_ctrl_pkg::crystal_t     crystal_o,
	output timer_clk_ctrl_pkg::kernel_clk_t  kernel_clk_o,
	output logic                             sample_tick_o,
	output logic                             compare_window_o,
	output logic                             update_event_o,
	output logic [CNT_W-1:0]                 counter_o
);
	import timer_clk_ctrl_pkg::*;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic        req;
	logic        known;
	logic        wr;
	logic [31:0] wmask;
	assign req   = cyc_i && stb_i && !ack_o && !err_o;
	assign known = adr_i == OFF_CONTROL_ONE || adr_i == OFF_ANALOG_CFG
		|| adr_i == OFF_CLOCK_SELECT || adr_i == OFF_SWITCH_DONE
		|| adr_i == OFF_COUNTER || adr_i == OFF_RELOAD
		|| adr_i == OFF_MODULE_ENABLE || adr_i == OFF_EVENT_STATUS;
	assign wr    = req && known && we_i;
	assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0]      ctrl_reg;
	logic [31:0]      ana_reg;
	logic [1:0]       clk_sel;
	logic             module_en;
	logic             encoder_mode;
	logic             update_flag;
	logic [CNT_W-1:0] reload_buf;
	logic [CNT_W-1:0] reload_act;
	logic [CNT_W-1:0] count;
	logic             hw_down;
	logic             upd;
	logic [3:0]       switch_cnt;
	logic [31:0]      ctrl_w;
	logic [31:0]      ana_w;
	logic             center;
	logic [31:0]      reload_buf_w;
	logic [31:0]      reload_act_w;
	logic [31:0]      count_w;

	assign center = ctrl_reg[POS_ALIGN +: 2] != 2'b00;
	assign ctrl_w = merge(ctrl_reg, dat_i, wmask);
	assign ana_w  = merge(ana_reg, dat_i, wmask);

	// ----------------------------------------
	// Byte-merged write values for counter-wide registers
	// ----------------------------------------
	assign reload_buf_w = merge(32'(reload_buf), dat_i, wmask);
	assign reload_act_w = merge(32'(reload_act), dat_i, wmask);
	assign count_w      = merge(32'(count), dat_i, wmask);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_reg <= RST_CONTROL_ONE;
		else if (wr && adr_i == OFF_CONTROL_ONE)
		begin
			// Bit 10 is reserved and stays zero
			ctrl_reg <= ctrl_w & 32'h0000_0bf1;
			if (center || encoder_mode)
				ctrl_reg[POS_DIR] <= hw_down;
			// Edge to center refused while counting
			if (ctrl_reg[POS_CNT_EN] && !center)
				ctrl_reg[POS_ALIGN +: 2] <= 2'b00;
		end
		else if (center || encoder_mode)
			ctrl_reg[POS_DIR] <= hw_down;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ana_reg <= RST_ANALOG_CFG;
		else if (wr && adr_i == OFF_ANALOG_CFG)
			ana_reg <= {19'h0, ana_w[12:0]};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			clk_sel    <= RST_CLOCK_SELECT[1:0];
			switch_cnt <= 4'h0;
		end
		else if (wr && adr_i == OFF_CLOCK_SELECT && sel_i[0] && dat_i[1:0] != clk_sel)
		begin
			clk_sel    <= dat_i[1:0];
			switch_cnt <= SWITCH_CYCLES;
		end
		else if (switch_cnt != 4'h0)
			switch_cnt <= switch_cnt - 4'h1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			module_en    <= 1'b0;
			encoder_mode <= 1'b0;
		end
		else if (wr && adr_i == OFF_MODULE_ENABLE && sel_i[0])
		begin
			module_en    <= dat_i[0];
			encoder_mode <= dat_i[POS_ENCODER];
		end
	end

	// ----------------------------------------
	// Reload path
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			reload_buf <= RST_RELOAD[CNT_W-1:0];
			reload_act <= RST_RELOAD[CNT_W-1:0];
		end
		else
		begin
			if (wr && adr_i == OFF_RELOAD)
				reload_buf <= reload_buf_w[CNT_W-1:0];
			if (wr && adr_i == OFF_RELOAD && !ctrl_reg[POS_PRELOAD])
				reload_act <= reload_act_w[CNT_W-1:0];
			else if (upd && ctrl_reg[POS_PRELOAD])
				reload_act <= reload_buf;
		end
	end

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	logic running;
	logic going_down;
	assign running    = ctrl_reg[POS_CNT_EN] && module_en;
	assign going_down = center ? hw_down : ctrl_reg[POS_DIR];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count   <= '0;
			hw_down <= 1'b0;
			upd     <= 1'b0;
		end
		else if (wr && adr_i == OFF_COUNTER)
		begin
			count <= count_w[CNT_W-1:0];
			upd   <= 1'b0;
		end
		else if (running)
		begin
			upd <= 1'b0;
			if (center)
			begin
				if (!hw_down && count + CNT_W'(1) >= reload_act)
				begin
					count   <= count + CNT_W'(1);
					hw_down <= 1'b1;
				end
				else if (hw_down && count <= CNT_W'(1))
				begin
					count   <= count - CNT_W'(1);
					hw_down <= 1'b0;
					upd     <= 1'b1;
				end
				else
					count <= hw_down ? count - CNT_W'(1) : count + CNT_W'(1);
			end
			else if (going_down)
			begin
				hw_down <= 1'b1;
				if (count == '0)
				begin
					count <= reload_act;
					upd   <= 1'b1;
				end
				else
					count <= count - CNT_W'(1);
			end
			else
			begin
				hw_down <= 1'b0;
				if (count >= reload_act)
				begin
					count <= '0;
					upd   <= 1'b1;
				end
				else
					count <= count + CNT_W'(1);
			end
		end
		else
			upd <= 1'b0;
	end

	// Update flag: set wins over software clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			update_flag <= 1'b0;
		else if (upd)
			update_flag <= 1'b1;
		else if (wr && adr_i == OFF_EVENT_STATUS && sel_i[0] && !dat_i[0])
			update_flag <= 1'b0;
	end

	// ----------------------------------------
	// Sampling clock divider
	// ----------------------------------------
	logic [1:0] div_cnt;
	logic [1:0] div_last;
	always_comb
	begin
		case (ctrl_reg[POS_SAMPLE_DIV +: 2])
			2'b00:   div_last = 2'd0;
			2'b01:   div_last = 2'd1;
			2'b10:   div_last = 2'd3;
			default: div_last = 2'd3;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			div_cnt       <= 2'd0;
			sample_tick_o <= 1'b0;
		end
		else
		begin
			div_cnt       <= (div_cnt >= div_last) ? 2'd0 : div_cnt + 2'd1;
			sample_tick_o <= div_cnt >= div_last;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic win;
	always_comb
	begin
		case (align_t'(ctrl_reg[POS_ALIGN +: 2]))
			ALIGN_EDGE: win = 1'b1;
			ALIGN_C1:   win = hw_down;
			ALIGN_C2:   win = !hw_down;
			ALIGN_C3:   win = 1'b1;
			default:    win = 1'b1;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			control_o        <= '0;
			crystal_o        <= '0;
			kernel_clk_o     <= KCLK_PLL;
			compare_window_o <= 1'b0;
			update_event_o   <= 1'b0;
			counter_o        <= '0;
		end
		else
		begin
			control_o <= {ctrl_reg[POS_REMAP], ctrl_reg[POS_SAMPLE_DIV +: 2],
				ctrl_reg[POS_PRELOAD], align_t'(ctrl_reg[POS_ALIGN +: 2]),
				ctrl_reg[POS_DIR], ctrl_reg[POS_CNT_EN]};
			crystal_o.crystal_freq_select        <= ana_reg[POS_FREQ_SEL];
			crystal_o.external_clock_path_select <= ana_reg[POS_EXT_PATH +: 2];
			crystal_o.crystal_path_select        <= ana_reg[POS_XTAL_PATH +: 2];
			crystal_o.xtal_osc_power <= ana_reg[POS_EXT_PATH +: 2] == 2'b00
				&& ana_reg[POS_XTAL_PATH +: 2] != 2'b00;
			kernel_clk_o     <= clk_sel[1] ? KCLK_XTAL : kernel_clk_t'(clk_sel);
			compare_window_o <= win && running;
			update_event_o   <= upd;
			counter_o        <= count;
		end
	end

	// ----------------------------------------
	// Read mux and acknowledge
	// ----------------------------------------
	logic [31:0] rd;
	always_comb
	begin
		rd = 32'h0;
		case (adr_i)
			OFF_CONTROL_ONE:   rd = ctrl_reg;
			OFF_ANALOG_CFG:    rd = ana_reg;
			OFF_CLOCK_SELECT:  rd = {30'h0, clk_sel};
			OFF_SWITCH_DONE:
			begin
				rd = RST_SWITCH_DONE;
				rd[POS_TIM0_DONE] = switch_cnt == 4'h0;
			end
			OFF_COUNTER:
			begin
				rd = 32'(count);
				rd[POS_UPD_FLAG] = ctrl_reg[POS_REMAP] && update_flag;
			end
			OFF_RELOAD:        rd = 32'(ctrl_reg[POS_PRELOAD] ? reload_buf : reload_act);
			OFF_MODULE_ENABLE: rd = {30'h0, encoder_mode, module_en};
			OFF_EVENT_STATUS:  rd = {31'h0, update_flag};
			default:           rd = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h0;
		end
		else
		begin
			ack_o <= req && known;
			err_o <= req && !known;
			dat_o <= (req && known && !we_i) ? rd : 32'h0;
		end
	end

endmodule

/* timer_clk_ctrl_pkg.sv */
package timer_clk_ctrl_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_CONTROL_ONE   = 8'h00;
	localparam logic [7:0] OFF_ANALOG_CFG    = 8'h10;
	localparam logic [7:0] OFF_CLOCK_SELECT  = 8'h44;
	localparam logic [7:0] OFF_SWITCH_DONE   = 8'h48;
	localparam logic [7:0] OFF_COUNTER       = 8'h24;
	localparam logic [7:0] OFF_RELOAD        = 8'h2c;
	localparam logic [7:0] OFF_MODULE_ENABLE = 8'h6c;
	localparam logic [7:0] OFF_EVENT_STATUS  = 8'h10 + 8'h80;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] RST_CONTROL_ONE  = 32'h0000_0000;
	localparam logic [31:0] RST_ANALOG_CFG   = 32'h0000_1850;
	localparam logic [31:0] RST_CLOCK_SELECT = 32'h0000_0000;
	localparam logic [31:0] RST_SWITCH_DONE  = 32'h0000_03ff;
	localparam logic [15:0] RST_RELOAD       = 16'hffff;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int POS_FREQ_SEL   = 4;
	localparam int POS_EXT_PATH   = 2;
	localparam int POS_XTAL_PATH  = 0;
	localparam int POS_REMAP      = 11;
	localparam int POS_SAMPLE_DIV = 8;
	localparam int POS_PRELOAD    = 7;
	localparam int POS_ALIGN      = 5;
	localparam int POS_DIR        = 4;
	localparam int POS_CNT_EN     = 0;
	localparam int POS_UPD_FLAG   = 31;
	localparam int POS_TIM0_DONE  = 2;
	localparam int POS_ENCODER    = 1;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int          SWITCH_TIME_NS = 100;
	localparam int          CLK_PERIOD_NS  = 10;
	localparam logic [3:0]  SWITCH_CYCLES  = 4'((SWITCH_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS);

	typedef enum logic [1:0] {KCLK_PLL, KCLK_LOW_SPEED_RC_OSC, KCLK_XTAL, KCLK_XTAL2} kernel_clk_t;
	typedef enum logic [1:0] {ALIGN_EDGE, ALIGN_C1, ALIGN_C2, ALIGN_C3} align_t;

	typedef struct packed {
		logic        update_flag_remap;
		logic [1:0]  sampling_clock_divide;
		logic        reload_preload_enable;
		align_t      center_align_select;
		logic        direction;
		logic        counter_enable;
	} control_t;

	typedef struct packed {
		logic        crystal_freq_select;
		logic [1:0]  external_clock_path_select;
		logic [1:0]  crystal_path_select;
		logic        xtal_osc_power;
	} crystal_t;

endpackage

/* timer_clock_select_control_properties.sv */
`timescale 1ns/100ps
module timer_clock_select_control_properties
	import timer_clk_ctrl_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  adr_i,
	input wire logic [31:0] dat_i,
	input wire logic        we_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire control_t    control_o,
	input wire crystal_t    crystal_o,
	input wire kernel_clk_t kernel_clk_o,
	input wire logic        sample_tick_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----
	// Properties
	// ----
	sequence s_sel_wr;
		cyc_i && stb_i && we_i && !ack_o && adr_i == OFF_CLOCK_SELECT && dat_i[1];
	endsequence
	property p_kernel_xtal;
		s_sel_wr |-> ##[1:2] kernel_clk_o == KCLK_XTAL;
	endproperty
	a_kernel_xtal: assert property (p_kernel_xtal) else $error("kernel clock wrong");
	property p_osc_power;
		crystal_o.xtal_osc_power == (crystal_o.external_clock_path_select == 2'h0
			&& crystal_o.crystal_path_select != 2'h0);
	endproperty
	a_osc_power: assert property (p_osc_power) else $error("oscillator power wrong");
	property p_ext_off;
		crystal_o.external_clock_path_select != 2'h0 |-> !crystal_o.xtal_osc_power;
	endproperty
	a_ext_off: assert property (p_ext_off) else $error("oscillator on with ext path");
	property p_freq_rst;
		$fell(rst_i) |=> crystal_o.crystal_freq_select;
	endproperty
	a_freq_rst: assert property (p_freq_rst) else $error("freq select reset wrong");
	property p_div2;
		control_o.sampling_clock_divide == 2'h1 && sample_tick_o
			|=> !sample_tick_o || control_o.sampling_clock_divide != 2'h1;
	endproperty
	a_div2: assert property (p_div2) else $error("tick too soon at div 2");
	property p_div4;
		control_o.sampling_clock_divide == 2'h2 && sample_tick_o
			|=> (!sample_tick_o || control_o.sampling_clock_divide != 2'h2) [*3];
	endproperty
	a_div4: assert property (p_div4) else $error("tick too soon at div 4");
	property p_no_remap;
		ack_o && $past(adr_i) == OFF_COUNTER && !$past(we_i)
			&& !control_o.update_flag_remap |-> !dat_o[31];
	endproperty
	a_no_remap: assert property (p_no_remap) else $error("flag in counter bit");
	property p_edge_hold;
		control_o.counter_enable && control_o.center_align_select == ALIGN_EDGE
			|=> control_o.center_align_select == ALIGN_EDGE;
	endproperty
	a_edge_hold: assert property (p_edge_hold) else $error("align left edge");
endmodule
bind timer_clock_select_control timer_clock_select_control_properties i_props (.clk_i, .rst_i,
	.adr_i, .dat_i, .we_i, .cyc_i, .stb_i, .dat_o, .ack_o, .control_o, .crystal_o,
	.kernel_clk_o, .sample_tick_o);

/* timer_clock_select_control_tb.sv */
`timescale 1ns/100ps
module timer_clock_select_control_tb;
	import timer_clk_ctrl_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0;
	logic [3:0]  sel_i = 4'hf;
	logic        we_i = 1'b0;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        err_o;
	control_t    control_o;
	crystal_t    crystal_o;
	kernel_clk_t kernel_clk_o;
	logic        sample_tick_o;
	logic        compare_window_o;
	logic        update_event_o;
	logic [15:0] counter_o;
	logic        er;
	logic [31:0] rd;
	logic [31:0] d;
	logic [31:0] seed = 32'h110a;
	logic [15:0] a;
	int          n;
	int          i;
	int          num_errors = 0;
	int          cmp_count = 0;
	logic [7:0]  adr_q[$] = '{OFF_CONTROL_ONE, OFF_ANALOG_CFG, OFF_CLOCK_SELECT, OFF_SWITCH_DONE};
	logic [31:0] rst_q[$] = '{RST_CONTROL_ONE, RST_ANALOG_CFG, RST_CLOCK_SELECT, RST_SWITCH_DONE};
	logic [1:0]  sel_q[$] = '{2'h1, 2'h2, 2'h3, 2'h0};
	logic [1:0]  kcl_q[$] = '{2'h1, 2'h2, 2'h2, 2'h0};

	always #5 clk_i = ~clk_i;

	timer_clock_select_control #(.CNT_W(16)) i_timer_clock_select_control (.clk_i, .rst_i,
		.adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .dat_o, .ack_o, .err_o, .control_o,
		.crystal_o, .kernel_clk_o, .sample_tick_o, .compare_window_o, .update_event_o,
		.counter_o);

	// ----
	// Helpers
	// ----
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic results;
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] wd);
		int t;
		adr_i <= ad;
		we_i <= w;
		dat_i <= wd;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		@(posedge clk_i);
		for (t = 0; t < 40 && ack_o !== 1'b1 && err_o !== 1'b1; t++)
			@(posedge clk_i);
		if (t == 40)
		begin
			num_errors++;
			results();
		end
		rd = dat_o;
		er = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// Cycles between two pulses of s
	task automatic gap(ref logic s, output int g);
		int t;
		@(posedge clk_i);
		for (t = 0; t < 40 && s !== 1'b1; t++)
			@(posedge clk_i);
		if (t == 40)
		begin
			num_errors++;
			results();
		end
		@(posedge clk_i);
		for (g = 1; g < 40 && s !== 1'b1; g++)
			@(posedge clk_i);
		if (g == 40)
		begin
			num_errors++;
			results();
		end
	endtask

	// ----
	// Main sequence
	// ----
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (i = 0; i < 4; i++)
		begin
			bus(adr_q[i], 1'b0, 32'h0);
			check(rd, rst_q[i]);
		end
		bus(8'h80, 1'b0, 32'h0);
		check(er, 1'b1);
		bus(OFF_SWITCH_DONE, 1'b1, 32'h0);
		bus(OFF_SWITCH_DONE, 1'b0, 32'h0);
		check(rd, RST_SWITCH_DONE);
		for (i = 0; i < 16; i++)
			if (i[3:2] != 2'h3 && i[1:0] != 2'h3)
			begin
				seed = xs(seed);
				d = (seed & 32'h1ff0) | i;
				bus(OFF_ANALOG_CFG, 1'b1, d);
				bus(OFF_ANALOG_CFG, 1'b0, 32'h0);
				check(rd, d & 32'h1fff);
				check(crystal_o[5:1], d[4:0]);
				check(crystal_o.xtal_osc_power, i[3:2] == 0 && i[1:0] != 0);
			end
		for (i = 0; i < 4; i++)
		begin
			bus(OFF_CLOCK_SELECT, 1'b1, 32'(sel_q[i]));
			bus(OFF_SWITCH_DONE, 1'b0, 32'h0);
			check(rd[POS_TIM0_DONE], 1'b0);
			repeat (12) @(posedge clk_i);
			bus(OFF_SWITCH_DONE, 1'b0, 32'h0);
			check(rd, RST_SWITCH_DONE);
			check(kernel_clk_o, kcl_q[i]);
		end
		for (i = 0; i < 3; i++)
		begin
			bus(OFF_CONTROL_ONE, 1'b1, i << POS_SAMPLE_DIV);
			gap(sample_tick_o, n);
			check(n, 1 << i);
		end
		bus(OFF_RELOAD, 1'b1, 32'h5);
		bus(OFF_MODULE_ENABLE, 1'b1, 32'h1);
		bus(OFF_CONTROL_ONE, 1'b1, 32'h801);
		gap(update_event_o, n);
		check(n, 6);
		a = counter_o;
		@(posedge clk_i);
		if (a != 16'h5)
			check(counter_o, a + 16'h1);
		bus(OFF_COUNTER, 1'b0, 32'h0);
		check(rd[POS_UPD_FLAG], 1'b1);
		bus(OFF_CONTROL_ONE, 1'b1, 32'h1);
		bus(OFF_COUNTER, 1'b0, 32'h0);
		check(rd[POS_UPD_FLAG], 1'b0);
		bus(OFF_CONTROL_ONE, 1'b1, 32'h21);
		bus(OFF_CONTROL_ONE, 1'b0, 32'h0);
		check(rd[6:5], 2'h0);
		bus(OFF_CONTROL_ONE, 1'b1, 32'h91);
		a = counter_o;
		@(posedge clk_i);
		if (a != 16'h0)
			check(counter_o, a - 16'h1);
		bus(OFF_RELOAD, 1'b1, 32'h2);
		bus(OFF_RELOAD, 1'b0, 32'h0);
		check(rd, 32'h2);
		gap(update_event_o, n);
		gap(update_event_o, n);
		check(n, 3);
		bus(OFF_CONTROL_ONE, 1'b1, 32'h0);
		bus(OFF_CONTROL_ONE, 1'b1, 32'h61);
		bus(OFF_CONTROL_ONE, 1'b0, 32'h0);
		check(rd[6:5], 2'h3);
		repeat (4) @(posedge clk_i);
		check(compare_window_o, 1'b1);
		results();
	end
endmodule
